// >>> design/rtcq_pkg.sv
/*
 * rtcq_pkg: constants and types for the remote-terminal command qualification block.
 * Assumes APB word indexing (byte address = 4 * index) and a 16-bit shared table RAM.
 */
package rtcq_pkg;

    // ------------------------------------------------------------
    // register and table word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] RTCQ_IDX_CFG      = 10'h001;
    localparam logic [9:0] RTCQ_IDX_SWADDR   = 10'h002;
    localparam logic [9:0] RTCQ_IDX_STATUS   = 10'h003;
    localparam logic [9:0] RTCQ_IDX_SELFTEST = 10'h004;
    localparam logic [9:0] RTCQ_IDX_ADDRRD   = 10'h005;
    localparam logic [9:0] RTCQ_IDX_LATCH    = 10'h006;
    localparam logic [9:0] RTCQ_IDX_ILL_BASE = 10'h300;
    localparam logic [9:0] RTCQ_IDX_BSY_BASE = 10'h240;
    localparam int         RTCQ_ILL_WORDS    = 256;
    localparam int         RTCQ_BSY_WORDS    = 8;
    localparam int         RTCQ_RAM_WORDS    = RTCQ_ILL_WORDS + RTCQ_BSY_WORDS;

    // ------------------------------------------------------------
    // configuration register fields
    // ------------------------------------------------------------
    localparam int          RTCQ_CFG_BUSY_N     = 0;
    localparam int          RTCQ_CFG_RX_BSY_ST  = 1;
    localparam int          RTCQ_CFG_AUTO_TFLAG = 2;
    localparam int          RTCQ_CFG_AUTO_SRQ   = 3;
    localparam int          RTCQ_CFG_SRC_LO     = 4;
    localparam int          RTCQ_CFG_LEGACY_A   = 6;
    localparam int          RTCQ_CFG_RSV_ILL    = 7;
    localparam int          RTCQ_CFG_BITQ_EN    = 8;
    localparam int          RTCQ_CFG_TF_INHIB   = 9;
    localparam logic [15:0] RTCQ_CFG_MASK       = 16'h03ff;
    localparam logic [15:0] RTCQ_CFG_RESET      = 16'h0001;

    // ------------------------------------------------------------
    // status word fields and software status register
    // ------------------------------------------------------------
    localparam int          RTCQ_ST_MERR   = 10;
    localparam int          RTCQ_ST_INSTR  = 9;
    localparam int          RTCQ_ST_SRQ    = 8;
    localparam int          RTCQ_ST_BCAST  = 4;
    localparam int          RTCQ_ST_BUSY   = 3;
    localparam int          RTCQ_ST_SUBSYS = 2;
    localparam int          RTCQ_ST_DBA    = 1;
    localparam int          RTCQ_ST_TFLAG  = 0;
    localparam logic [15:0] RTCQ_STAT_MASK = 16'h0307;
    localparam logic [15:0] RTCQ_STAT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // command fields, mode codes, self-test and queue
    // ------------------------------------------------------------
    localparam logic [4:0]  RTCQ_BCAST_ADDR   = 5'h1f;
    localparam logic [4:0]  RTCQ_MC_TX_VECTOR = 5'h10;
    localparam int          RTCQ_BIT_TF_INHIB = 9;
    localparam logic [15:0] RTCQ_BIT_RESET    = 16'h0000;
    localparam int          RTCQ_VEC_BIT_DONE = 3;

    typedef enum logic [1:0] {RTCQ_SRC_PIN, RTCQ_SRC_STROBE, RTCQ_SRC_SOFT, RTCQ_SRC_REG} rtcq_src_t;
    typedef enum logic [1:0] {RTCQ_S_IDLE, RTCQ_S_ILL, RTCQ_S_BSY, RTCQ_S_FIN} rtcq_state_t;

endpackage : rtcq_pkg

// >>> design/rtcq_addr_if.sv
/*
 * rtcq_addr_if: terminal address source control between the core and the address selector.
 * Assumes both ends run on the same clock.
 */
interface rtcq_addr_if;
    import rtcq_pkg::*;
    rtcq_src_t  src;
    logic [4:0] sw_addr;
    logic       sw_par;
    logic       sw_latch;
    logic [4:0] cur_addr;
    logic       cur_par;
    logic       par_ok;

    modport ctl (output src, sw_addr, sw_par, sw_latch, input cur_addr, cur_par, par_ok);
    modport sel (input src, sw_addr, sw_par, sw_latch, output cur_addr, cur_par, par_ok);
endinterface : rtcq_addr_if

// >>> design/rtcq_addr_sel.sv
/*
 * rtcq_addr_sel: synchronises the address pins and picks the terminal address source.
 * Assumes the pins are asynchronous to pclk and change slowly against it.
 */
module rtcq_addr_sel
    import rtcq_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // pins
    input  wire logic [4:0] rt_addr_pin,
    input  wire logic       rt_addr_parity_pin,
    input  wire logic       address_latch_strobe,
    // core side
    rtcq_addr_if.sel        aif
);
    logic [6:0] s1, s2, s3, stable;
    logic       stb_prev;
    logic [5:0] hw_lat, sw_lat;
    wire  logic [5:0] pins_now = stable[5:0];
    wire  logic       stb_rise = stable[6] & ~stb_prev;
    logic [5:0] pick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 7'h00;
            s2 <= 7'h00;
            s3 <= 7'h00;
        end else begin
            s1 <= {address_latch_strobe, rt_addr_parity_pin, rt_addr_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a bit moves only once the second and third stages agree
    for (genvar i = 0; i < 7; i++) begin : g_filt
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) stable[i] <= 1'b0;
            else if (s2[i] == s3[i]) stable[i] <= s3[i];
        end
    end

    always_comb begin
        case (aif.src)
            RTCQ_SRC_PIN:    pick = pins_now;
            RTCQ_SRC_STROBE: pick = hw_lat;
            RTCQ_SRC_SOFT:   pick = sw_lat;
            RTCQ_SRC_REG:    pick = {aif.sw_par, aif.sw_addr};
            default:         pick = pins_now;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stb_prev     <= 1'b0;
            hw_lat       <= 6'h00;
            sw_lat       <= 6'h00;
            aif.cur_addr <= 5'h00;
            aif.cur_par  <= 1'b0;
            aif.par_ok   <= 1'b0;
        end else begin
            stb_prev <= stable[6];
            if (stb_rise) hw_lat <= pins_now;
            if (aif.sw_latch) sw_lat <= pins_now;
            aif.cur_addr <= pick[4:0];
            aif.cur_par  <= pick[5];
            aif.par_ok   <= ^pick; // odd parity over address and parity bit
        end
    end
endmodule : rtcq_addr_sel

// >>> design/rtcq_top.sv
/*
 * rtcq_top: remote-terminal command qualification and status-word control.
 * Holds the illegal-command and busy tables, builds the status word for each command,
 * keeps the self-test word and the terminal address, all reached over APB.
 * Assumes the protocol engine on pclk hands over validated commands addressed to us or broadcast.
 */
// How it works
// - every command is checked against the host-written illegal table in RAM
// - illegal table is words 300-3FF: bcast rx, bcast tx, own rx, own tx
// - two words per subaddress; low word codes 15-0, high word 31-16
// - subaddress 0 and 31 (only 0 with the legacy option set) index by mode code, others by word count
// - global busy control at zero makes all non-broadcast commands busy
// - busy table picks any of 128 address-type, direction, subaddress combinations
// - busy transmit sends status with busy set and no data words
// - busy receive returns status with busy set
// - option chooses storing or discarding data of busy non-mode receives
// - address comes from pins, strobe latch, software latch or register
// - strobe latch captures address and parity on strobe rising edge
// - host can read back the address in use
// - terminal flag set by software or automatically on loop test failure
// - optional service request clear after transmit vector word mode command
// - software programs status word content and self-test word
// - options for legacy mode codes and reserved mode codes
// - self-test word bits 15 to 8 as listed
// - self-test word bits 7 to 0 as listed
// - self-test done gives a non-message queue entry with vector bit 0 low
module rtcq_top
    import rtcq_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // validated command from the protocol engine
    input  wire logic              cmd_valid,
    input  wire logic [15:0]       cmd_word,
    // response decision
    output logic                   resp_valid,
    output logic      [15:0]       resp_status,
    output logic                   resp_illegal,
    output logic                   resp_busy,
    output logic                   resp_send_data,
    output logic                   resp_store_data,
    // terminal address pins
    input  wire logic [4:0]        rt_addr_pin,
    input  wire logic              rt_addr_parity_pin,
    input  wire logic              address_latch_strobe,
    // self-test events
    input  wire logic [15:0]       bit_event,
    input  wire logic              loop_test_fail,
    input  wire logic              bit_complete,
    // interrupt status queue entry
    output logic                   isq_valid,
    output logic      [15:0]       isq_vector
);
    import rtcq_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mode(input logic [4:0] sa, input logic legacy);
        // legacy terminals use only subaddress 0 for mode codes
        is_mode = (sa == 5'h00) || (!legacy && sa == 5'h1f);
    endfunction : is_mode

    function automatic logic is_reserved_mc(input logic [4:0] mc);
        is_reserved_mc = (mc >= 5'h09 && mc <= 5'h0f) || (mc >= 5'h16);
    endfunction : is_reserved_mc

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]  cfg;
    logic [5:0]   sw_addr_reg;
    logic [15:0]  stat_sw;
    logic [15:0]  selftest;
    logic         sw_latch;
    logic         apb_rd_wait;
    logic [15:0]  ram [RTCQ_RAM_WORDS];
    logic [15:0]  ram_q;
    rtcq_state_t  state;
    logic [15:0]  cmd_q;
    logic         ill_bit;

    rtcq_addr_if aif ();

    // ------------------------------------------------------------
    // address selector
    // ------------------------------------------------------------
    assign aif.src      = rtcq_src_t'(cfg[RTCQ_CFG_SRC_LO +: 2]);
    assign aif.sw_addr  = sw_addr_reg[4:0];
    assign aif.sw_par   = sw_addr_reg[5];
    assign aif.sw_latch = sw_latch;

    rtcq_addr_sel u_addr_sel (
        .pclk                 (pclk),
        .presetn              (presetn),
        .rt_addr_pin          (rt_addr_pin),
        .rt_addr_parity_pin   (rt_addr_parity_pin),
        .address_latch_strobe (address_latch_strobe),
        .aif                  (aif)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic [9:0] widx      = paddr[11:2];
    wire logic       acc       = psel & penable;
    wire logic       done      = acc & pready;
    wire logic       hit_ill   = (widx[9:8] == RTCQ_IDX_ILL_BASE[9:8]);
    wire logic       hit_bsy   = (widx[9:3] == RTCQ_IDX_BSY_BASE[9:3]);
    wire logic       hit_ram   = hit_ill | hit_bsy;
    wire logic       hit_cfg   = (widx == RTCQ_IDX_CFG);
    wire logic       hit_swad  = (widx == RTCQ_IDX_SWADDR);
    wire logic       hit_stat  = (widx == RTCQ_IDX_STATUS);
    wire logic       hit_bit   = (widx == RTCQ_IDX_SELFTEST);
    wire logic       hit_adrd  = (widx == RTCQ_IDX_ADDRRD);
    wire logic       hit_latch = (widx == RTCQ_IDX_LATCH);
    wire logic       hit_reg   = hit_cfg | hit_swad | hit_stat | hit_bit | hit_adrd | hit_latch;
    wire logic [8:0] apb_ridx  = hit_ill ? {1'b0, widx[7:0]} : {6'b100000, widx[2:0]};
    wire logic       wr_done   = done & pwrite;

    logic [15:0] reg_rdata;
    always_comb begin
        reg_rdata = 16'h0000;
        if (hit_cfg)  reg_rdata = cfg;
        if (hit_swad) reg_rdata = {10'h000, sw_addr_reg};
        if (hit_stat) reg_rdata = stat_sw;
        if (hit_bit)  reg_rdata = selftest;
        if (hit_adrd) reg_rdata = {9'h000, aif.par_ok, 6'h00} | {10'h000, aif.cur_par, aif.cur_addr};
    end

    // ------------------------------------------------------------
    // command fields and table addressing
    // ------------------------------------------------------------
    wire logic [4:0] c_addr   = cmd_q[15:11];
    wire logic       c_tr     = cmd_q[10];
    wire logic [4:0] c_sa     = cmd_q[9:5];
    wire logic [4:0] c_code   = cmd_q[4:0]; // word count and mode code share these bits
    wire logic       c_bcast  = (c_addr == RTCQ_BCAST_ADDR);
    wire logic       c_mode   = is_mode(c_sa, cfg[RTCQ_CFG_LEGACY_A]);
    // quarter order: bcast rx, bcast tx, own rx, own tx; two words per subaddress
    wire logic [8:0] ill_idx  = {1'b0, ~c_bcast, c_tr, c_sa, c_code[4]};
    wire logic [8:0] bsy_idx  = {6'b100000, ~c_bcast, c_tr, c_sa[4]};
    wire logic       fsm_port = (state == RTCQ_S_ILL) || (state == RTCQ_S_BSY);
    wire logic [8:0] rd_idx   = (state == RTCQ_S_ILL) ? ill_idx : (state == RTCQ_S_BSY) ? bsy_idx : apb_ridx;

    // ------------------------------------------------------------
    // decision terms, valid in the final lookup state
    // ------------------------------------------------------------
    wire logic rsv_hit  = c_mode & cfg[RTCQ_CFG_RSV_ILL] & is_reserved_mc(c_code);
    wire logic illegal  = ill_bit | rsv_hit;
    wire logic tbl_busy = ram_q[c_sa[3:0]];
    wire logic gbl_busy = ~cfg[RTCQ_CFG_BUSY_N] & ~c_bcast;
    wire logic busy     = tbl_busy | gbl_busy;
    wire logic tflag    = stat_sw[RTCQ_ST_TFLAG] & ~cfg[RTCQ_CFG_TF_INHIB];
    wire logic srq_clr  = (state == RTCQ_S_FIN) & cfg[RTCQ_CFG_AUTO_SRQ] & c_mode & c_tr
                          & (c_code == RTCQ_MC_TX_VECTOR) & ~illegal;
    wire logic tf_set   = loop_test_fail & cfg[RTCQ_CFG_AUTO_TFLAG];
    wire logic [15:0] status_now = {aif.cur_addr, illegal, stat_sw[RTCQ_ST_INSTR], stat_sw[RTCQ_ST_SRQ],
                                    3'b000, c_bcast, busy, stat_sw[RTCQ_ST_SUBSYS],
                                    stat_sw[RTCQ_ST_DBA], tflag};
    wire logic [15:0] bit_set = bit_event
                                | ({15'h0000, cfg[RTCQ_CFG_TF_INHIB]} << RTCQ_BIT_TF_INHIB);

    // ------------------------------------------------------------
    // shared table ram: one write port for the host, one read port shared
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (wr_done && hit_ram) ram[apb_ridx] <= pwdata[15:0];
        ram_q <= ram[rd_idx];
    end

    // ------------------------------------------------------------
    // apb slave: registers answer after one wait, ram reads after two
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            apb_rd_wait <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (acc && !pready) begin
                if (hit_ram && !pwrite) begin
                    // the lookup owns the read port; the host read waits behind it
                    if (apb_rd_wait) begin
                        pready      <= 1'b1;
                        prdata      <= {16'h0000, ram_q};
                        apb_rd_wait <= 1'b0;
                    end else if (!fsm_port) begin
                        apb_rd_wait <= 1'b1;
                    end
                end else begin
                    pready  <= 1'b1;
                    pslverr <= ~(hit_reg | hit_ram);
                    prdata  <= {16'h0000, pwrite ? 16'h0000 : reg_rdata};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg         <= RTCQ_CFG_RESET;
            sw_addr_reg <= 6'h00;
            sw_latch    <= 1'b0;
        end else begin
            sw_latch <= wr_done & hit_latch;
            if (wr_done && hit_cfg)  cfg <= pwdata[15:0] & RTCQ_CFG_MASK;
            if (wr_done && hit_swad) sw_addr_reg <= pwdata[5:0];
        end
    end

    // a hardware set lands on top of a same-cycle software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_sw  <= RTCQ_STAT_RESET;
            selftest <= RTCQ_BIT_RESET;
        end else begin
            if (wr_done && hit_stat) begin
                stat_sw <= (pwdata[15:0] & RTCQ_STAT_MASK) | {15'h0000, tf_set};
            end else begin
                if (tf_set)  stat_sw[RTCQ_ST_TFLAG] <= 1'b1;
                if (srq_clr) stat_sw[RTCQ_ST_SRQ]   <= 1'b0;
            end
            selftest <= ((wr_done && hit_bit) ? pwdata[15:0] : selftest) | bit_set;
        end
    end

    // ------------------------------------------------------------
    // lookup sequence: illegal word, then busy word, then decide
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= RTCQ_S_IDLE;
            cmd_q   <= 16'h0000;
            ill_bit <= 1'b0;
        end else begin
            case (state)
                RTCQ_S_IDLE: begin
                    if (cmd_valid) begin
                        cmd_q <= cmd_word;
                        state <= RTCQ_S_ILL;
                    end
                end
                RTCQ_S_ILL: state <= RTCQ_S_BSY;
                RTCQ_S_BSY: begin
                    ill_bit <= ram_q[c_code[3:0]];
                    state   <= RTCQ_S_FIN;
                end
                RTCQ_S_FIN: state <= RTCQ_S_IDLE;
                default:    state <= RTCQ_S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // response to the protocol engine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_valid      <= 1'b0;
            resp_status     <= 16'h0000;
            resp_illegal    <= 1'b0;
            resp_busy       <= 1'b0;
            resp_send_data  <= 1'b0;
            resp_store_data <= 1'b0;
        end else begin
            resp_valid <= (state == RTCQ_S_FIN);
            if (state == RTCQ_S_FIN) begin
                resp_status     <= status_now;
                resp_illegal    <= illegal;
                resp_busy       <= busy;
                resp_send_data  <= c_tr & ~busy & ~illegal;
                resp_store_data <= ~c_tr & ~illegal & (~busy | (cfg[RTCQ_CFG_RX_BSY_ST] & ~c_mode));
            end
        end
    end

    // ------------------------------------------------------------
    // self-test completion queue entry
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isq_valid  <= 1'b0;
            isq_vector <= 16'h0000;
        end else begin
            isq_valid <= bit_complete & cfg[RTCQ_CFG_BITQ_EN];
            if (bit_complete) isq_vector <= 16'h0001 << RTCQ_VEC_BIT_DONE;
        end
    end
endmodule : rtcq_top

// >>> tb/rtcq_sva.sv
/* rtcq_sva: response and queue checks on the ports of rtcq_top.
   Assumes one clock pclk and presetn as asynchronous active-low reset. */
module rtcq_sva (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // command and response
    input wire logic        cmd_valid,
    input wire logic        resp_valid,
    input wire logic [15:0] resp_status,
    input wire logic        resp_illegal,
    input wire logic        resp_busy,
    input wire logic        resp_send_data,
    input wire logic        resp_store_data,
    // self-test queue
    input wire logic        bit_complete,
    input wire logic        isq_valid,
    input wire logic [15:0] isq_vector
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // edges left before another command is taken; commands inside that span are dropped
    logic [1:0] hold_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold_cnt <= 2'h0;
        else if (cmd_valid && hold_cnt == 2'h0) hold_cnt <= 2'h3;
        else if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
    end
    sequence cmd_taken; cmd_valid && hold_cnt == 2'h0; endsequence
    sequence resp_out; !resp_valid [*3] ##1 resp_valid ##1 !resp_valid; endsequence
    resp_timing_a: assert property (cmd_taken |=> resp_out)
        else $error("late response");
    status_flags_a: assert property (resp_valid |-> resp_status[10] == resp_illegal && resp_status[3] == resp_busy)
        else $error("status flags differ");
    busy_no_data_a: assert property (resp_valid && resp_busy |-> !resp_send_data)
        else $error("busy transmit sends data");
    illegal_no_data_a: assert property (resp_valid && resp_illegal |-> !resp_send_data && !resp_store_data)
        else $error("illegal command moves data");
    one_direction_a: assert property (resp_valid && resp_send_data |-> !resp_store_data)
        else $error("send and store together");
    flags_hold_a: assert property (!resp_valid |-> $stable({resp_illegal, resp_busy, resp_status}))
        else $error("response moved");
    isq_entry_a: assert property (isq_valid |-> !isq_vector[0] && $past(bit_complete))
        else $error("stray queue entry");
    isq_pulse_a: assert property (isq_valid |=> !isq_valid)
        else $error("long queue entry");
endmodule : rtcq_sva

bind rtcq_top rtcq_sva u_sva (.pclk, .presetn, .cmd_valid, .resp_valid, .resp_status, .resp_illegal,
    .resp_busy, .resp_send_data, .resp_store_data, .bit_complete, .isq_valid, .isq_vector);

// >>> tb/rtcq_bc_model.sv
/* rtcq_bc_model: bus controller side, hands one validated command word at a time.
   Assumes the block answers each taken command with one resp_valid pulse. */
module rtcq_bc_model (
    // clock
    input wire logic         pclk,
    // command out
    output logic             cmd_valid,
    output logic      [15:0] cmd_word,
    // response in
    input wire logic         resp_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cmd_valid, cmd_word} = 17'h00000;
    // word is inverted after the pulse so a late sample cannot pass by luck
    task automatic issue(input logic [15:0] w);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_word  <= w;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        cmd_word  <= ~w;
        for (int n = 0; n < 8 && resp_valid !== 1'b1; n++) @(posedge pclk);
    endtask : issue
endmodule : rtcq_bc_model

// >>> tb/rtcq_top_tb_top.sv
/* rtcq_top_tb_top: APB and command tests of rtcq_top.
   Assumes the bus controller model and the bound port checker. */
module rtcq_top_tb_top import rtcq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, rt_addr_parity_pin = '0;
    logic        address_latch_strobe = '0, loop_test_fail = '0, bit_complete = '0, last_err, isq_valid;
    logic        pready, pslverr, cmd_valid, resp_valid, resp_illegal, resp_busy, resp_send_data, resp_store_data;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [15:0] cmd_word, resp_status, isq_vector, q, bit_event = '0;
    logic [4:0]  rt_addr_pin = '0;
    int          err_total = 0, checks_done = 0;
    // {own, tr, sa, code}
    logic [11:0] cs [4] = '{12'h825, 12'hff1, 12'h003, 12'h7d4};
    rtcq_top DUT (.*);
    rtcq_bc_model bc (.*);
    initial forever #20 pclk = ~pclk;
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        stop_test();
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, 16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
        q = prdata[15:0];
        last_err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // flags are {illegal, busy, send, store}
    task automatic go(input logic [15:0] w, input logic [3:0] e);
        bc.issue(w);
        `CHK("resp flags", e, {resp_illegal, resp_busy, resp_send_data, resp_store_data})
        `CHK("status merr busy", e[3:2], {resp_status[RTCQ_ST_MERR], resp_status[RTCQ_ST_BUSY]})
    endtask : go
    task automatic pulse_in(input logic [1:0] s);
        {bit_event, loop_test_fail} <= {s[0] ? 16'h8001 : 16'h0000, s[1]};
        @(posedge pclk);
        {bit_event, loop_test_fail} <= 17'h00000;
    endtask : pulse_in
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, RTCQ_IDX_CFG, 0);
        `CHK("cfg reset", RTCQ_CFG_RESET, q)
        apb(0, RTCQ_IDX_SELFTEST, 0);
        `CHK("selftest reset", RTCQ_BIT_RESET, q)
        apb(0, 10'h000, 0);
        `CHK("unmapped error", 1'b1, last_err)
        for (int i = 0; i < 264; i++) apb(1, (i < 256) ? 10'(12'h300 + i) : 10'(12'h140 + i), 0);
        $display("test reset done");
        foreach (cs[k]) begin
            apb(1, {2'b11, cs[k][11:4]}, 16'h0001 << cs[k][3:0]);
            go({cs[k][11] ? 5'h05 : 5'h1f, cs[k][10:0]}, 4'b1000);
            go({cs[k][11] ? 5'h05 : 5'h1f, cs[k][10:1], ~cs[k][0]}, {2'b00, cs[k][10], ~cs[k][10]});
            apb(1, {2'b11, cs[k][11:4]}, 0);
        end
        $display("test illegal table done");
        apb(1, RTCQ_IDX_CFG, 16'h0000);
        go(16'h2825, 4'b0100);
        go(16'hf825, 4'b0001);
        go(16'h2c41, 4'b0100);
        apb(1, RTCQ_IDX_CFG, 16'h0001);
        apb(1, 10'h246, 16'h0004);
        apb(1, 10'h244, 16'h0004);
        go(16'h2c41, 4'b0100);
        go(16'h2c61, 4'b0010);
        go(16'h2841, 4'b0100);
        apb(1, RTCQ_IDX_CFG, 16'h0003);
        go(16'h2841, 4'b0101);
        $display("test busy done");
        apb(1, RTCQ_IDX_CFG, 16'h0031);
        apb(1, RTCQ_IDX_SWADDR, 16'h002a);
        apb(0, RTCQ_IDX_ADDRRD, 0);
        `CHK("register address", 6'h2a, q[5:0])
        rt_addr_pin <= 5'h13;
        apb(1, RTCQ_IDX_CFG, 16'h0011);
        repeat (8) @(posedge pclk);
        address_latch_strobe <= 1'b1;
        repeat (8) @(posedge pclk);
        rt_addr_pin <= 5'h04;
        rt_addr_parity_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, RTCQ_IDX_ADDRRD, 0);
        `CHK("strobe address", 6'h13, q[5:0])
        apb(1, RTCQ_IDX_CFG, 16'h0021);
        apb(1, RTCQ_IDX_LATCH, 0);
        rt_addr_pin <= 5'h1c;
        repeat (8) @(posedge pclk);
        apb(0, RTCQ_IDX_ADDRRD, 0);
        `CHK("soft latch address", 6'h24, q[5:0])
        apb(1, RTCQ_IDX_CFG, 16'h0001);
        apb(0, RTCQ_IDX_ADDRRD, 0);
        `CHK("pin address", 6'h3c, q[5:0])
        $display("test address done");
        pulse_in(2'b01);
        apb(0, RTCQ_IDX_SELFTEST, 0);
        `CHK("selftest events", 16'h8001, q)
        apb(1, RTCQ_IDX_SELFTEST, 16'h0100);
        apb(0, RTCQ_IDX_SELFTEST, 0);
        `CHK("selftest write", 16'h0100, q)
        apb(1, RTCQ_IDX_STATUS, 16'h0100);
        apb(1, RTCQ_IDX_CFG, 16'h000d);
        pulse_in(2'b10);
        go(16'h2c10, 4'b0010);
        apb(0, RTCQ_IDX_STATUS, 0);
        `CHK("status after vector", 16'h0001, q)
        apb(1, RTCQ_IDX_CFG, 16'h0101);
        bit_complete <= 1'b1;
        @(posedge pclk);
        bit_complete <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("queue vector", 16'h0001 << RTCQ_VEC_BIT_DONE, isq_vector)
        $display("test status done");
        stop_test();
    end
endmodule : rtcq_top_tb_top
